//--- core/lcp_map.svh
// Offsets, field positions, reset values and timing counts of the limit comparator.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
// Behaviour
// - Judge high, pass or low per parameter.
// - Separate limit pair per parameter, judged independently.
// - Combined pass only when both parameters pass.
// - Comparator mode survives power loss.
// - Power loss during editing discards the edit.
// - Disabled limit skipped; display shows dashes.
// - Comparator mode forces fixed range.
// - Confirm stores and advances through four limits.
// - Mode key advances without storing.
// - Cursor held two seconds disables; count restores.
// - Limits kept as raw display counts.
// - No range or ordering check on limits.
// - Overflow, underflow, lower, upper, then pass.
// - Both limits disabled gives no judgment.
// - Enter comparator mode if any limit enabled.
// - Beep on judgment per beep setting.
// - Comparator mode locks conditions except trigger.
// - Manual trigger starts one measurement when external.
// - Store up to 99 panels with conditions and limits.
// - Save offers first unused panel, else one.
// - Confirm writes panel and returns.
// - Alternate key aborts save without writing.
`ifndef LCP_MAP_SVH
`define LCP_MAP_SVH
`define LCP_A_CTRL   8'h00
`define LCP_A_COND   8'h04
`define LCP_A_LIM0   8'h08
`define LCP_A_STAT   8'h18
`define LCP_A_JUDGE  8'h1C
`define LCP_A_PIDX   8'h20
`define LCP_A_PDAT   8'h24
`define LCP_CTRL_BEEP 1:0
`define LCP_CTRL_EXT  2
`define LCP_CTRL_AUTO 3
`define LCP_COND_RST 16'h0000
`define LCP_BEEP_OFF 2'h0
`define LCP_BEEP_IN  2'h1
`define LCP_BEEP_NG  2'h2
`define LCP_NPANEL   99
`define LCP_HOLD_MS  2000
`define LCP_CLK_MHZ  100
`define LCP_HOLD_CYC (`LCP_HOLD_MS * 1000 * `LCP_CLK_MHZ)
`endif

//--- core/lcp_pkg.sv
// Types of the limit comparator and panel store.
// Constants live in lcp_map.svh.
package lcp_pkg;
	typedef enum logic [1:0] {M_NORM, M_EDIT, M_COMP, M_SAVE} mode_t;
	typedef struct packed {
		logic        off;
		logic [15:0] cnt;
	} lim_t;
	typedef struct packed {
		logic hi;
		logic in;
		logic lo;
	} judge_t;
	typedef struct packed {
		logic        done;
		logic        ovf;
		logic        unf;
		logic [15:0] first;
		logic [15:0] second;
	} meas_t;
	typedef struct packed {
		mode_t       mode;
		mode_t       prev;
		logic [1:0]  eidx;
		lim_t        ed;
		lim_t [3:0]  lim;
		logic [15:0] cond;
		logic        external_trigger_source;
		logic        autor;
		logic [1:0]  beep_sel;
		logic [6:0]  pnum;
		logic [6:0]  pidx;
		logic [98:0] used;
		logic [27:0] hold;
		judge_t [1:0] jg;
		logic        pass;
		logic        beep;
		logic        start;
		logic        trigger_select_key_d;
		logic        awv;
		logic        wv;
		logic        bv;
		logic        berr;
		logic        rv;
		logic        rerr;
		logic [7:0]  awa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic [31:0] rd;
	} st_t;
endpackage : lcp_pkg

//--- core/limit_comparator_panel_store.sv
// Limit comparator with limit editing, mode control and a 99-entry panel store.
// Assumes keys arrive as one-cycle pulses synchronous to i_clk; i_rst is a full reboot,
// while i_pwr_fail marks a power loss that the battery-backed state survives.
`timescale 1ns/1ps
`include "lcp_map.svh"
module limit_comparator_panel_store #(
	parameter logic [27:0] HOLD_CYC = 28'(`LCP_HOLD_CYC)
) (
	// Clock and reset.
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	// AXI4-Lite slave.
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	output logic [1:0]         s_axi_bresp,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	input  wire logic [7:0]    s_axi_araddr,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	// Front panel keys and edited value.
	input  wire logic          i_key_mode,
	input  wire logic          i_key_enter,
	input  wire logic          i_key_count,
	input  wire logic          i_key_loadsave,
	input  wire logic          i_trigger_select_key,
	input  wire logic          i_manual_trigger_key,
	input  wire logic          i_cursor_end_held,
	input  wire logic [15:0]   i_edit_value,
	input  wire logic          i_pwr_fail,
	// Measurement engine.
	input  wire lcp_pkg::meas_t i_meas,
	input  wire logic          i_ext_trigger_select_key_n,
	output logic               o_meas_start,
	output logic               o_fixed_range,
	output logic               o_external_trigger_source,
	// Parallel judgment port and beeper.
	output logic [1:0]         o_judge_high,
	output logic [1:0]         o_judge_in,
	output logic [1:0]         o_judge_low,
	output logic               o_pass_and,
	output logic               o_beep,
	// Status indicators and display.
	output logic               o_first_upper_edit_ind,
	output logic               o_first_lower_edit_ind,
	output logic               o_second_upper_edit_ind,
	output logic               o_second_lower_edit_ind,
	output logic               o_comp_mode,
	output logic               o_edit_dashes,
	output logic [15:0]        o_edit_value
);
	lcp_pkg::st_t s_r;
	lcp_pkg::st_t s_nxt;
	logic [83:0]  mem [0:`LCP_NPANEL-1];
	logic         wr_go;
	logic         save_go;
	logic [6:0]   free_num;
	lcp_pkg::judge_t [1:0] jg_new;
	logic [31:0]  rmux;
	logic         rhit;

	// Lowest unused panel number, or one when every panel is used.
	always_comb
	begin
		free_num = 7'h01;
		for (int k = `LCP_NPANEL - 1; k >= 0; k--)
		begin
			if (!s_r.used[k])
				free_num = 7'(k + 1);
		end
	end

	// Per-parameter judgment from raw counts, lower limit first.
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_judge
			lcp_pkg::lim_t up;
			lcp_pkg::lim_t lo;
			logic [15:0]   v;
			assign up = s_r.lim[2 * g];
			assign lo = s_r.lim[2 * g + 1];
			assign v  = (g == 0) ? i_meas.first : i_meas.second;
			always_comb
			begin
				jg_new[g] = '0;
				if (up.off && lo.off)
					jg_new[g] = '0;
				else if (i_meas.ovf)
					jg_new[g].hi = 1'b1;
				else if (i_meas.unf)
					jg_new[g].lo = 1'b1;
				else if (!lo.off && v <= lo.cnt)
					jg_new[g].lo = 1'b1;
				else if (!up.off && v >= up.cnt)
					jg_new[g].hi = 1'b1;
				else
					jg_new[g].in = 1'b1;
			end
		end
	endgenerate

	// Register read multiplexer.
	always_comb
	begin
		rmux = '0;
		rhit = 1'b1;
		unique case (s_axi_araddr)
			`LCP_A_CTRL: rmux = {28'h0, s_r.autor, s_r.external_trigger_source, s_r.beep_sel};
			`LCP_A_COND: rmux = {16'h0, s_r.cond};
			`LCP_A_LIM0: rmux = {15'h0, s_r.lim[0]};
			8'h0C:       rmux = {15'h0, s_r.lim[1]};
			8'h10:       rmux = {15'h0, s_r.lim[2]};
			8'h14:       rmux = {15'h0, s_r.lim[3]};
			`LCP_A_STAT: rmux = {16'h0, 1'b0, s_r.pnum, 2'h0, s_r.eidx, s_r.prev, s_r.mode};
			`LCP_A_JUDGE: rmux = {25'h0, s_r.pass, s_r.jg};
			`LCP_A_PIDX: rmux = {25'h0, s_r.pidx};
			`LCP_A_PDAT: rmux = {s_r.used[s_r.pidx], 15'h0, mem[s_r.pidx][83:68]};
			default:     rhit = 1'b0;
		endcase
	end

	assign wr_go   = s_r.awv && s_r.wv && !s_r.bv;
	assign save_go = (s_r.mode == lcp_pkg::M_SAVE) && i_key_enter;

	always_comb
	begin
		logic any_on;
		logic lock;
		any_on = 1'b0;
		lock   = 1'b0;
		s_nxt       = s_r;
		s_nxt.beep  = 1'b0;
		s_nxt.start = 1'b0;
		s_nxt.trigger_select_key_d = i_ext_trigger_select_key_n;
		// Bus channels.
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_nxt.awv = 1'b1;
			s_nxt.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_nxt.wv = 1'b1;
			s_nxt.wd = s_axi_wdata;
			s_nxt.ws = s_axi_wstrb;
		end
		if (s_r.bv && s_axi_bready)
			s_nxt.bv = 1'b0;
		if (s_r.rv && s_axi_rready)
			s_nxt.rv = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_nxt.rv   = 1'b1;
			s_nxt.rd   = rmux;
			s_nxt.rerr = !rhit;
		end
		lock = (s_r.mode == lcp_pkg::M_COMP);
		if (wr_go)
		begin
			s_nxt.awv  = 1'b0;
			s_nxt.wv   = 1'b0;
			s_nxt.bv   = 1'b1;
			s_nxt.berr = 1'b0;
			unique case (s_r.awa)
				`LCP_A_CTRL:
				begin
					if (s_r.ws[0])
					begin
						s_nxt.external_trigger_source = s_r.wd[`LCP_CTRL_EXT];
						if (!lock)
						begin
							s_nxt.beep_sel = s_r.wd[`LCP_CTRL_BEEP];
							s_nxt.autor    = s_r.wd[`LCP_CTRL_AUTO];
						end
					end
				end
				`LCP_A_COND:
				begin
					if (!lock && s_r.ws[0])
						s_nxt.cond[7:0] = s_r.wd[7:0];
					if (!lock && s_r.ws[1])
						s_nxt.cond[15:8] = s_r.wd[15:8];
				end
				`LCP_A_PIDX:
				begin
					if (s_r.ws[0] && s_r.wd[6:0] < 7'(`LCP_NPANEL))
						s_nxt.pidx = s_r.wd[6:0];
				end
				`LCP_A_LIM0, 8'h0C, 8'h10, 8'h14, `LCP_A_STAT, `LCP_A_JUDGE, `LCP_A_PDAT:
					s_nxt.berr = 1'b0;
				default:
					s_nxt.berr = 1'b1;
			endcase
		end
		// Trigger source and measurement start.
		if (i_trigger_select_key && s_r.mode inside {lcp_pkg::M_NORM, lcp_pkg::M_COMP})
			s_nxt.external_trigger_source = !s_nxt.external_trigger_source;
		if (s_r.external_trigger_source && (i_manual_trigger_key || (s_r.trigger_select_key_d && !i_ext_trigger_select_key_n)))
			s_nxt.start = 1'b1;
		// Mode sequencing.
		unique case (s_r.mode)
			lcp_pkg::M_NORM:
			begin
				if (i_key_mode)
				begin
					s_nxt.mode = lcp_pkg::M_EDIT;
					s_nxt.eidx = 2'h0;
					s_nxt.ed   = s_r.lim[0];
					s_nxt.hold = '0;
				end
				else if (i_key_loadsave)
				begin
					s_nxt.mode = lcp_pkg::M_SAVE;
					s_nxt.prev = lcp_pkg::M_NORM;
					s_nxt.pnum = free_num;
				end
			end
			lcp_pkg::M_EDIT:
			begin
				if (i_pwr_fail)
					s_nxt.mode = lcp_pkg::M_NORM;
				else if (i_key_enter || i_key_mode)
				begin
					if (i_key_enter)
						s_nxt.lim[s_r.eidx] = s_r.ed;
					s_nxt.eidx = s_r.eidx + 2'h1;
					s_nxt.ed   = s_nxt.lim[s_r.eidx + 2'h1];
					s_nxt.hold = '0;
					if (s_r.eidx == 2'h3)
					begin
						for (int k = 0; k < 4; k++)
							any_on = any_on | !s_nxt.lim[k].off;
						s_nxt.mode = any_on ? lcp_pkg::M_COMP : lcp_pkg::M_NORM;
					end
				end
				else if (i_key_count)
				begin
					s_nxt.ed.off = 1'b0;
					s_nxt.ed.cnt = i_edit_value;
					s_nxt.hold   = '0;
				end
				else if (i_cursor_end_held)
				begin
					if (s_r.hold >= HOLD_CYC - 28'h1)
						s_nxt.ed.off = 1'b1;
					else
						s_nxt.hold = s_r.hold + 28'h1;
				end
				else
					s_nxt.hold = '0;
			end
			lcp_pkg::M_COMP:
			begin
				if (i_key_mode)
					s_nxt.mode = lcp_pkg::M_NORM;
				else if (i_key_loadsave)
				begin
					s_nxt.mode = lcp_pkg::M_SAVE;
					s_nxt.prev = lcp_pkg::M_COMP;
					s_nxt.pnum = free_num;
				end
				if (i_meas.done)
				begin
					s_nxt.jg   = jg_new;
					s_nxt.pass = jg_new[0].in && jg_new[1].in;
					unique case (s_r.beep_sel)
						`LCP_BEEP_IN: s_nxt.beep = jg_new[0].in && jg_new[1].in;
						`LCP_BEEP_NG: s_nxt.beep = !(jg_new[0].in && jg_new[1].in);
						default:      s_nxt.beep = 1'b0;
					endcase
				end
			end
			lcp_pkg::M_SAVE:
			begin
				if (i_key_enter)
				begin
					s_nxt.used[s_r.pnum - 7'h1] = 1'b1;
					s_nxt.mode = s_r.prev;
				end
				else if (i_key_mode || i_key_loadsave)
					s_nxt.mode = s_r.prev;
				else if (i_key_count)
					s_nxt.pnum = (s_r.pnum >= 7'(`LCP_NPANEL)) ? 7'h01 : s_r.pnum + 7'h1;
			end
		endcase
		if (s_nxt.mode != lcp_pkg::M_COMP)
		begin
			s_nxt.jg   = '0;
			s_nxt.pass = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s_r      <= '0;
			s_r.cond <= `LCP_COND_RST;
			s_r.pnum <= 7'h01;
			s_r.trigger_select_key_d <= 1'b1;
			for (int k = 0; k < 4; k++)
				s_r.lim[k].off <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// Panel store keeps conditions and all four limits.
	always_ff @(posedge i_clk)
	begin
		if (save_go)
			mem[s_r.pnum - 7'h1] <= {s_r.cond, s_r.lim};
	end

	assign s_axi_awready = !s_r.awv && !s_r.bv;
	assign s_axi_wready  = !s_r.wv && !s_r.bv;
	assign s_axi_bvalid  = s_r.bv;
	assign s_axi_bresp   = s_r.berr ? 2'h2 : 2'h0;
	assign s_axi_arready = !s_r.rv;
	assign s_axi_rvalid  = s_r.rv;
	assign s_axi_rdata   = s_r.rd;
	assign s_axi_rresp   = s_r.rerr ? 2'h2 : 2'h0;
	assign o_meas_start  = s_r.start;
	assign o_fixed_range = !s_r.autor || s_r.mode == lcp_pkg::M_COMP;
	assign o_external_trigger_source = s_r.external_trigger_source;
	assign o_judge_high  = {s_r.jg[1].hi, s_r.jg[0].hi};
	assign o_judge_in    = {s_r.jg[1].in, s_r.jg[0].in};
	assign o_judge_low   = {s_r.jg[1].lo, s_r.jg[0].lo};
	assign o_pass_and    = s_r.pass;
	assign o_beep        = s_r.beep;
	assign o_comp_mode   = s_r.mode == lcp_pkg::M_COMP;
	assign o_first_upper_edit_ind  = s_r.mode == lcp_pkg::M_EDIT && s_r.eidx == 2'h0;
	assign o_first_lower_edit_ind  = s_r.mode == lcp_pkg::M_EDIT && s_r.eidx == 2'h1;
	assign o_second_upper_edit_ind = s_r.mode == lcp_pkg::M_EDIT && s_r.eidx == 2'h2;
	assign o_second_lower_edit_ind = s_r.mode == lcp_pkg::M_EDIT && s_r.eidx == 2'h3;
	assign o_edit_dashes = s_r.mode == lcp_pkg::M_EDIT && s_r.ed.off;
	assign o_edit_value  = s_r.ed.cnt;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	pass_and_a: assert property (o_pass_and == (o_judge_in == 2'h3))
		else $error("pass output disagrees with judgments");
	judge_onehot_a: assert property ($countones({o_judge_high[0], o_judge_in[0], o_judge_low[0]}) <= 1)
		else $error("first parameter judgment not one-hot");
	both_off_a: assert property (o_comp_mode && s_r.lim[2].off && s_r.lim[3].off |-> o_judge_high[1] == 1'b0 &&
		o_judge_in[1] == 1'b0 && o_judge_low[1] == 1'b0)
		else $error("judgment shown with both limits off");
	comp_range_a: assert property (o_comp_mode |-> o_fixed_range)
		else $error("auto ranging active in comparator mode");
	manual_start_a: assert property (i_manual_trigger_key && o_external_trigger_source |=> o_meas_start)
		else $error("manual trigger lost");
	int_nostart_a: assert property (!o_external_trigger_source |=> !o_meas_start)
		else $error("start without external source");
	ovf_high_a: assert property (o_comp_mode && i_meas.done && i_meas.ovf && !i_key_mode && !i_key_loadsave
		&& !s_r.lim[0].off |=> o_judge_high[0])
		else $error("overflow not judged high");
	abort_save_a: assert property (s_r.mode == lcp_pkg::M_SAVE && !i_key_enter && i_key_mode |=>
		s_r.used == $past(s_r.used) && s_r.mode == $past(s_r.prev))
		else $error("aborted save changed store");
	skip_store_a: assert property (s_r.mode == lcp_pkg::M_EDIT && i_key_mode && !i_key_enter && !i_pwr_fail |=>
		s_r.lim == $past(s_r.lim) && s_r.eidx == $past(s_r.eidx) + 2'h1)
		else $error("mode key stored a limit");
	cond_lock_a: assert property (o_comp_mode |=> s_r.cond == $past(s_r.cond))
		else $error("conditions changed in comparator mode");

	judge_pass_c: cover property (o_comp_mode && i_meas.done ##1 o_pass_and);
	save_done_c: cover property (s_r.mode == lcp_pkg::M_SAVE && i_key_enter);
	edit_off_c: cover property (o_edit_dashes ##1 i_key_count);
endmodule : limit_comparator_panel_store

//--- tb/lcp_handler.sv
// External handler on the parallel judgment port.
// Shares the comparator clock; the trigger line idles high as if pulled up.
`timescale 1ns/1ps
module lcp_handler (
	input  wire logic i_clk,
	input  wire logic i_fire,
	input  wire logic i_meas_start,
	output logic      o_trigger_select_key_n,
	output int        o_starts
);
	int low_cnt;
	initial
	begin
		o_trigger_select_key_n = 1'b1;
		o_starts = 0;
		low_cnt  = 0;
	end
	// A fire request gives one low-going pulse of three cycles.
	always @(posedge i_clk)
	begin
		if (i_fire)
			low_cnt <= 3;
		else if (low_cnt > 0)
			low_cnt <= low_cnt - 1;
		o_trigger_select_key_n <= !(i_fire || low_cnt > 1);
		if (i_meas_start === 1'b1)
			o_starts <= o_starts + 1;
	end
endmodule : lcp_handler

//--- tb/limit_comparator_panel_store_tb.sv
// Self-checking bench of the limit comparator and panel store.
// Drives keys, measurements and AXI4-Lite from one 100 MHz clock.
`timescale 1ns/1ps
`include "lcp_map.svh"
module limit_comparator_panel_store_tb;
	localparam int KM = 0, KE = 1, KC = 2, KL = 3, KT = 4, KG = 5, KP = 6;
	logic           i_clk, i_rst, cur, fire, trigger_select_key_n, mstart, fixr, extsrc, pass, beep, comp, dash;
	logic           awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic           ind0, ind1, ind2, ind3;
	logic [7:0]     awaddr, araddr;
	logic [31:0]    wdata, rdata, d;
	logic [1:0]     bresp, rresp, rr, br, jh, ji, jl;
	logic [6:0]     keys;
	logic [15:0]    ev, eval;
	lcp_pkg::meas_t meas;
	int             starts, fails, checks_done;

	limit_comparator_panel_store #(.HOLD_CYC(28'd20)) DUT (
		.i_clk(i_clk), .i_rst(i_rst),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.i_key_mode(keys[KM]), .i_key_enter(keys[KE]), .i_key_count(keys[KC]),
		.i_key_loadsave(keys[KL]), .i_trigger_select_key(keys[KT]),
		.i_manual_trigger_key(keys[KG]), .i_cursor_end_held(cur), .i_edit_value(ev),
		.i_pwr_fail(keys[KP]), .i_meas(meas), .i_ext_trigger_select_key_n(trigger_select_key_n), .o_meas_start(mstart),
		.o_fixed_range(fixr), .o_external_trigger_source(extsrc),
		.o_judge_high(jh), .o_judge_in(ji), .o_judge_low(jl), .o_pass_and(pass), .o_beep(beep),
		.o_first_upper_edit_ind(ind0), .o_first_lower_edit_ind(ind1),
		.o_second_upper_edit_ind(ind2), .o_second_lower_edit_ind(ind3),
		.o_comp_mode(comp), .o_edit_dashes(dash), .o_edit_value(eval)
	);

	lcp_handler handler (
		.i_clk(i_clk), .i_fire(fire), .i_meas_start(mstart), .o_trigger_select_key_n(trigger_select_key_n), .o_starts(starts)
	);

	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic summarize;
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task automatic press(input int k);
		@(posedge i_clk);
		keys[k] <= 1'b1;
		@(posedge i_clk);
		keys <= '0;
		#1;
	endtask : press

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ha, hw, hb;
		@(posedge i_clk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		hb = 1'b0;
		while (!hb)
		begin
			@(negedge i_clk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			br = bresp;
			@(posedge i_clk);
			if (ha)
				awvalid <= 1'b0;
			if (hw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic ha, hr;
		@(posedge i_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		hr = 1'b0;
		while (!hr)
		begin
			@(negedge i_clk);
			ha = arvalid && arready;
			hr = rvalid;
			v = rdata;
			r = rresp;
			@(posedge i_clk);
			if (ha)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		#1;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a, d, rr);
		chk(d & m, e);
	endtask : rc

	task automatic setlim(input logic [15:0] v);
		@(posedge i_clk);
		ev <= v;
		press(KC);
		press(KE);
	endtask : setlim

	// Expected is {beep, pass, second hi/in/lo, first hi/in/lo}.
	task automatic mz(input logic [15:0] f, input logic [15:0] s, input logic [1:0] ou, input logic [7:0] e);
		@(posedge i_clk);
		meas <= {1'b1, ou, f, s};
		@(posedge i_clk);
		meas.done <= 1'b0;
		#1;
		chk({beep, pass, jh[1], ji[1], jl[1], jh[0], ji[0], jl[0]}, e);
	endtask : mz

	initial
	begin
		i_rst = 1'b1;
		keys = '0;
		cur = 1'b0;
		ev = '0;
		meas = '0;
		fire = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		fails = 0;
		checks_done = 0;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		#1;
		chk(fixr, 1);
		rc(`LCP_A_STAT, 32'h7F03, 32'h100);
		rd(8'h30, d, rr);
		chk(rr, 2);
		wr(8'h30, 32'h0);
		chk(br, 2'h2);
		wr(`LCP_A_CTRL, 32'h9);
		wr(`LCP_A_COND, 32'h1234);
		chk(fixr, 0);
		press(KM);
		chk(ind0, 1);
		setlim(16'd100);
		chk(ind1, 1);
		setlim(16'd50);
		chk(ind2, 1);
		setlim(16'd300);
		chk(ind3, 1);
		press(KC);
		chk(dash, 0);
		@(posedge i_clk);
		cur <= 1'b1;
		repeat (10) @(posedge i_clk);
		#1;
		chk(dash, 0);
		repeat (12) @(posedge i_clk);
		cur <= 1'b0;
		#1;
		chk(dash, 1);
		press(KE);
		chk(comp, 1);
		chk(fixr, 1);
		rc(`LCP_A_LIM0, 32'h1FFFF, 32'h64);
		rc(8'h0C, 32'h1FFFF, 32'h32);
		rc(8'h10, 32'h1FFFF, 32'h12C);
		rc(8'h14, 32'h10000, 32'h10000);
		mz(16'd51, 16'd10, 2'b00, 8'hD2);
		mz(16'd100, 16'd300, 2'b00, 8'h24);
		mz(16'd50, 16'd0, 2'b00, 8'h11);
		mz(16'd51, 16'd10, 2'b10, 8'h24);
		mz(16'd51, 16'd10, 2'b01, 8'h09);
		wr(`LCP_A_CTRL, 32'h0);
		chk(br, 2'h0);
		rc(`LCP_A_CTRL, 32'hF, 32'h9);
		wr(`LCP_A_COND, 32'h5555);
		rc(`LCP_A_COND, 32'hFFFF, 32'h1234);
		press(KG);
		repeat (3) @(posedge i_clk);
		chk(starts, 0);
		press(KT);
		chk(extsrc, 1);
		press(KG);
		repeat (3) @(posedge i_clk);
		chk(starts, 1);
		@(posedge i_clk);
		fire <= 1'b1;
		@(posedge i_clk);
		fire <= 1'b0;
		repeat (8) @(posedge i_clk);
		chk(starts, 2);
		press(KL);
		rc(`LCP_A_STAT, 32'h7F03, 32'h103);
		press(KE);
		rc(`LCP_A_STAT, 32'h3, 32'h2);
		press(KL);
		rc(`LCP_A_STAT, 32'h7F03, 32'h203);
		press(KC);
		rc(`LCP_A_STAT, 32'h7F03, 32'h303);
		press(KM);
		rc(`LCP_A_STAT, 32'h3, 32'h2);
		wr(`LCP_A_PIDX, 32'h0);
		rc(`LCP_A_PDAT, 32'h8000FFFF, 32'h80001234);
		wr(`LCP_A_PIDX, 32'h1);
		rc(`LCP_A_PDAT, 32'h80000000, 32'h0);
		press(KP);
		chk(comp, 1);
		press(KM);
		chk({comp, jh, ji, jl, pass}, 0);
		press(KM);
		@(posedge i_clk);
		ev <= 16'd7;
		press(KC);
		chk(eval, 16'h7);
		press(KP);
		rc(`LCP_A_STAT, 32'h3, 32'h0);
		rc(`LCP_A_LIM0, 32'h1FFFF, 32'h64);
		press(KM);
		press(KC);
		press(KM);
		chk(ind1, 1);
		rc(`LCP_A_LIM0, 32'h1FFFF, 32'h64);
		wr(`LCP_A_CTRL, 32'h6);
		press(KM);
		chk(ind2, 1);
		@(posedge i_clk);
		cur <= 1'b1;
		repeat (22) @(posedge i_clk);
		cur <= 1'b0;
		#1;
		chk(dash, 1);
		press(KE);
		rc(8'h10, 32'h10000, 32'h10000);
		press(KM);
		chk(comp, 1);
		mz(16'd51, 16'd10, 2'b00, 8'h82);
		mz(16'd100, 16'd300, 2'b00, 8'h84);
		summarize();
	end

	initial
	begin
		#400us;
		fails++;
		summarize();
	end
endmodule : limit_comparator_panel_store_tb
